/* File: rtl/vfd_pkg.sv */
// vfd_pkg: constants and types of the fetch and dispatch block.
// assumes: one core clock; instruction fields laid out as below.
package vfd_pkg;

   localparam int FP_WORDS = 8;
   localparam int INSN_W = 32;
   localparam int FP_W = 256;
   localparam int CHAIN_BIT = 0;
   localparam int UNIT_LSB = 1;
   localparam int XPATH_BIT = 4;
   localparam int SRC_LSB = 5;
   localparam int DST_LSB = 10;
   localparam int OP_LSB = 15;
   localparam int SIMD_LSB = 19;
   localparam int STORE_BIT = 21;
   localparam int SIZE_LSB = 22;
   localparam logic [31:0] RESET_PC = 32'h0000_0000;
   localparam logic [31:0] FP_BYTES = 32'h0000_0020;
   localparam logic [3:0] MOP_MAX = 4'h9;
   localparam logic [3:0] EP_MAX = 4'h8;

   typedef enum logic [2:0] {U_L1, U_S1, U_M1, U_D1, U_D2, U_M2, U_S2, U_L2} vfd_unit_type;

   typedef enum logic [3:0] {
      MOP_MUL2X16, MOP_MUL4X8, MOP_MUL16X32, MOP_DMULADD, MOP_DMULSUB,
      MOP_QMULADD, MOP_BITCNT, MOP_ROTATE, MOP_GFMUL, MOP_VSHIFT, MOP_NONE
   } vfd_mop_type;

   typedef enum logic [1:0] {SIMD_W32, SIMD_D16, SIMD_Q8, SIMD_NONE} vfd_simd_type;

   typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_DWORD} vfd_msize_type;

   typedef struct packed {
      logic valid;
      vfd_unit_type unit;
      logic xpath;
      logic [4:0] src;
      logic [4:0] dst;
      vfd_mop_type mop;
      vfd_simd_type simd;
      logic mem;
      logic store;
      vfd_msize_type size;
      logic [31:0] insn;
   } vfd_slot_type;

   typedef vfd_slot_type [FP_WORDS-1:0] vfd_bundle_type;
   typedef logic [FP_WORDS-1:0][INSN_W-1:0] vfd_fp_type;

endpackage : vfd_pkg

/* File: rtl/vfd_insn_decode.sv */
// vfd_insn_decode: splits one instruction word into its unit slot fields.
// assumes: purely combinational, fed from registered words.
`timescale 1ns/100ps
`default_nettype none
module vfd_insn_decode
   import vfd_pkg::*;
(
   input wire logic valid,
   input wire logic [31:0] insn,
   output var vfd_slot_type slot
);

   always_comb
   begin
      slot = '0;
      slot.valid = valid;
      slot.insn = insn;
      slot.unit = vfd_unit_type'(insn[UNIT_LSB +: 3]);
      slot.xpath = insn[XPATH_BIT];
      slot.src = insn[SRC_LSB +: 5];
      slot.dst = insn[DST_LSB +: 5];
      slot.mop = MOP_NONE;
      slot.simd = SIMD_NONE;
      slot.size = SZ_WORD;
      case (slot.unit)
         U_M1, U_M2:
         begin
            // multiply units own every multiply flavour
            if (insn[OP_LSB +: 4] <= MOP_MAX)
               slot.mop = vfd_mop_type'(insn[OP_LSB +: 4]); // [RQ11] [RQ12]
         end
         U_D1, U_D2:
         begin
            slot.mem = 1'b1;
            slot.store = insn[STORE_BIT];
            slot.size = vfd_msize_type'(insn[SIZE_LSB +: 2]); // [RQ14]
         end
         default:
         begin
            // alu and shift/branch units: 32, 2x16 or 4x8 lanes
            if (insn[SIMD_LSB +: 2] != 2'h3)
               slot.simd = vfd_simd_type'(insn[SIMD_LSB +: 2]); // [RQ13]
            else
               slot.simd = SIMD_W32;
         end
      endcase
   end

endmodule : vfd_insn_decode
`default_nettype wire

/* File: rtl/vfd_xpath_hazard.sv */
// vfd_xpath_hazard: flags a cross path read of a register written last cycle.
// assumes: prev holds the packet issued in the cycle before cand.
`timescale 1ns/100ps
`default_nettype none
module vfd_xpath_hazard
   import vfd_pkg::*;
(
   input wire vfd_bundle_type cand,
   input wire vfd_bundle_type prev,
   output logic stall
);

   always_comb
   begin
      stall = 1'b0;
      for (int r = 0; r < FP_WORDS; r++)
      begin
         for (int w = 0; w < FP_WORDS; w++)
         begin
            // writer side opposite the reader means the read crosses over
            if (cand[r].valid && cand[r].xpath && prev[w].valid && !prev[w].store
                && prev[w].dst == cand[r].src && prev[w].unit[2] != cand[r].unit[2])
               stall = 1'b1; // [RQ15]
         end
      end
   end

endmodule : vfd_xpath_hazard
`default_nettype wire

/* File: rtl/vfd_fetch_dispatch.sv */
// vfd_fetch_dispatch: fetches 256-bit packets, splits execute packets, issues them.
// assumes: program memory answers a held request with one rvalid pulse.
`timescale 1ns/100ps
`default_nettype none

// Operation
// RQ1: fetch one 256-bit packet of eight words
// RQ2: route each 32-bit word to its unit
// RQ3: lsb one chains next word into packet
// RQ4: lsb zero ends the execute packet
// RQ5: at most eight words per execute packet
// RQ6: execute packets may cross fetch packet boundaries
// RQ7: one to eight execute packets per fetch
// RQ8: issue one execute packet per clock
// RQ9: next fetch only after all packets issued
// RQ10: all addressed units driven in same cycle
// RQ11: multiply units do 2x16 or 4x8 multiplies
// RQ12: multiply units add mac, rotate, gf, shifts
// RQ13: alu units do 32, 2x16, 4x8 ops
// RQ14: memory access in byte to doubleword sizes
// RQ15: stall once on cross path read-after-write
// RQ16: buffer partial packet until next fetch arrives
module vfd_fetch_dispatch
   import vfd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   output logic pmem_req,
   output logic [31:0] pmem_addr,
   input wire logic pmem_rvalid,
   input wire vfd_fp_type pmem_rdata,
   output var vfd_bundle_type fu_issue
);

   typedef enum logic {ST_FETCH, ST_DISP} vfd_state_type;

   vfd_state_type state_q;
   vfd_state_type state_d;
   logic [31:0] pc_q;
   logic [31:0] pc_d;
   vfd_fp_type fp_q;
   vfd_fp_type fp_d;
   logic [2:0] pos_q;
   logic [2:0] pos_d;
   vfd_fp_type carry_q;
   vfd_fp_type carry_d;
   logic [3:0] carry_cnt_q;
   logic [3:0] carry_cnt_d;
   vfd_bundle_type issue_q;
   vfd_bundle_type issue_d;

   vfd_fp_type pkt_w;
   logic [7:0] pkt_v;
   logic [3:0] cnt;
   logic [2:0] last_pos;
   logic ended;
   logic crosses;
   vfd_bundle_type dec;
   vfd_bundle_type routed;
   logic xp_stall;
   logic [7:0] iss_v;

   // gather the next execute packet from carry and fetch packet
   always_comb
   begin
      pkt_w = carry_q;
      pkt_v = 8'h00;
      for (int k = 0; k < FP_WORDS; k++)
      begin
         if (4'(k) < carry_cnt_q)
            pkt_v[k] = 1'b1; // [RQ16]
      end
      cnt = carry_cnt_q;
      ended = 1'b0;
      last_pos = pos_q;
      for (int i = 0; i < FP_WORDS; i++)
      begin
         if (!ended && 3'(i) >= pos_q)
         begin
            pkt_w[cnt[2:0]] = fp_q[i];
            pkt_v[cnt[2:0]] = 1'b1; // [RQ3]
            cnt = cnt + 4'h1;
            last_pos = 3'(i); // [RQ7]
            if (!fp_q[i][CHAIN_BIT] || cnt == EP_MAX)
               ended = 1'b1; // [RQ4] [RQ5]
         end
      end
      crosses = !ended; // [RQ6]
   end

   generate
      for (genvar k = 0; k < FP_WORDS; k++)
      begin : g_dec
         vfd_insn_decode u_dec (
            .valid(pkt_v[k]),
            .insn(pkt_w[k]),
            .slot(dec[k])
         );
      end
   endgenerate

   // steer every word of the packet to the slot of its unit
   always_comb
   begin
      routed = '0;
      for (int u = 0; u < FP_WORDS; u++)
      begin
         for (int k = 0; k < FP_WORDS; k++)
         begin
            if (dec[k].valid && dec[k].unit == vfd_unit_type'(u))
               routed[u] = dec[k]; // [RQ2]
         end
      end
   end

   vfd_xpath_hazard u_haz (
      .cand(routed),
      .prev(issue_q),
      .stall(xp_stall)
   );

   always_comb
   begin
      state_d = state_q;
      pc_d = pc_q;
      fp_d = fp_q;
      pos_d = pos_q;
      carry_d = carry_q;
      carry_cnt_d = carry_cnt_q;
      issue_d = '0;
      case (state_q)
         ST_FETCH:
         begin
            if (pmem_rvalid)
            begin
               fp_d = pmem_rdata; // [RQ1]
               pos_d = 3'h0;
               state_d = ST_DISP;
            end
         end
         ST_DISP:
         begin
            if (crosses)
            begin
               // park the open packet, fetch its tail
               carry_d = pkt_w; // [RQ16]
               carry_cnt_d = cnt;
               pc_d = pc_q + FP_BYTES;
               state_d = ST_FETCH; // [RQ6]
            end
            else if (!xp_stall) // [RQ15]
            begin
               issue_d = routed; // [RQ8] [RQ10]
               carry_cnt_d = 4'h0;
               if (last_pos == 3'h7)
               begin
                  pc_d = pc_q + FP_BYTES;
                  state_d = ST_FETCH; // [RQ9]
               end
               else
               begin
                  pos_d = last_pos + 3'h1;
               end
            end
         end
         default:
         begin
            state_d = ST_FETCH;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q <= ST_FETCH;
         pc_q <= RESET_PC;
         fp_q <= '0;
         pos_q <= 3'h0;
         carry_q <= '0;
         carry_cnt_q <= 4'h0;
         issue_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         pc_q <= pc_d;
         fp_q <= fp_d;
         pos_q <= pos_d;
         carry_q <= carry_d;
         carry_cnt_q <= carry_cnt_d;
         issue_q <= issue_d;
      end
   end

   assign pmem_req = (state_q == ST_FETCH); // [RQ9]
   assign pmem_addr = pc_q;
   assign fu_issue = issue_q;

   generate
      for (genvar u = 0; u < FP_WORDS; u++)
      begin : g_iv
         assign iss_v[u] = issue_q[u].valid;
      end
   endgenerate

   // checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   a_fetch_align: assert property ( // [RQ1]
      pmem_req |-> pmem_addr[4:0] == 5'h00)
      else $error("fetch address not packet aligned");

   a_fetch_load: assert property ( // [RQ1]
      pmem_req && pmem_rvalid |=> state_q == ST_DISP && pos_q == 3'h0
         && fp_q == $past(pmem_rdata))
      else $error("fetched packet not loaded");

   generate
      for (genvar u = 0; u < FP_WORDS; u++)
      begin : g_chk
         a_route_unit: assert property ( // [RQ2]
            issue_q[u].valid |-> issue_q[u].unit == vfd_unit_type'(u))
            else $error("instruction issued to wrong unit");
         a_mul_unit: assert property ( // [RQ11]
            issue_q[u].valid && issue_q[u].mop != MOP_NONE
               |-> issue_q[u].unit == U_M1 || issue_q[u].unit == U_M2)
            else $error("multiply op outside multiply unit");
         a_mem_unit: assert property ( // [RQ14]
            issue_q[u].valid && issue_q[u].mem
               |-> issue_q[u].unit == U_D1 || issue_q[u].unit == U_D2)
            else $error("memory access outside data unit");
      end
   endgenerate

   a_chain_cross: assert property ( // [RQ6]
      state_q == ST_DISP && crosses |=> pmem_req && carry_cnt_q == $past(cnt)
         && pc_q == $past(pc_q) + FP_BYTES)
      else $error("open packet not carried over");

   a_eight_cap: assert property ( // [RQ5]
      state_q == ST_DISP && cnt == EP_MAX |-> !crosses && $countones(pkt_v) == 8)
      else $error("execute packet exceeds eight words");

   a_stall_bubble: assert property ( // [RQ15]
      state_q == ST_DISP && !crosses && xp_stall |=> iss_v == 8'h00
         && state_q == ST_DISP && !xp_stall ##1 iss_v != 8'h00)
      else $error("cross path stall not a single bubble");

   a_pos_hold: assert property ( // [RQ15]
      state_q == ST_DISP && !crosses && xp_stall |=> $stable(pos_q) && $stable(carry_cnt_q))
      else $error("stalled packet moved on");

   a_hold_fetch: assert property ( // [RQ9]
      state_q == ST_DISP && !crosses && !xp_stall && last_pos != 3'h7
         |=> !pmem_req && pos_q == $past(last_pos) + 3'h1)
      else $error("fetch before packet fully issued");

   // fetch side: request holds, steps one packet, gates issue
   a_req_hold: assert property ( // [RQ9]
      pmem_req && !pmem_rvalid |=> pmem_req && $stable(pmem_addr))
      else $error("fetch request dropped before answer");

   a_addr_step: assert property ( // [RQ9]
      $rose(pmem_req) |-> pmem_addr == $past(pmem_addr) + FP_BYTES)
      else $error("fetch address did not step one packet");

   a_quiet_fetch: assert property ( // [RQ9]
      pmem_req |=> iss_v == 8'h00)
      else $error("packet issued while fetching");

   // dispatch side: a closed packet without a cross path stall leaves on the next edge
   a_issue_follow: assert property ( // [RQ8]
      state_q == ST_DISP && !crosses && !xp_stall |=> iss_v != 8'h00)
      else $error("closed packet not issued next cycle");

   a_xpath_quiet: assert property ( // [RQ15]
      iss_v == 8'h00 |-> !xp_stall)
      else $error("stall without a preceding writer");

   a_carry_keep: assert property ( // [RQ16]
      state_q == ST_FETCH |=> $stable(carry_q) && $stable(carry_cnt_q))
      else $error("partial packet lost while fetching");

   a_carry_head: assert property ( // [RQ16]
      state_q == ST_DISP && carry_cnt_q != 4'h0 |-> pos_q == 3'h0)
      else $error("carried words not joined to packet head");

   a_issue_src: assert property ( // [RQ8]
      iss_v != 8'h00 |-> $past(state_q) == ST_DISP && !$past(crosses))
      else $error("issue outside a dispatch cycle");

   a_end_packet: assert property ( // [RQ4]
      state_q == ST_DISP && !crosses |-> !fp_q[last_pos][CHAIN_BIT] || cnt == EP_MAX)
      else $error("packet closed on a chained word");

   c_cross: cover property (state_q == ST_DISP && crosses ##[1:20] iss_v != 8'h00);
   c_stall: cover property (state_q == ST_DISP && !crosses && xp_stall);
   c_full: cover property (iss_v == 8'hff);
   c_cap: cover property (state_q == ST_DISP && !crosses && cnt == EP_MAX && fp_q[last_pos][CHAIN_BIT]);
   c_back: cover property (iss_v != 8'h00 ##1 iss_v != 8'h00 ##1 iss_v != 8'h00);

endmodule : vfd_fetch_dispatch
`default_nettype wire

/* File: sim/vfd_pmem_model.sv */
// vfd_pmem_model: program memory answering each held fetch request once.
// assumes: bench loads prog and slow while reset is held.
`timescale 1ns/100ps
`default_nettype none
module vfd_pmem_model
   import vfd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic pmem_req,
   input wire logic [31:0] pmem_addr,
   output logic pmem_rvalid,
   output var vfd_fp_type pmem_rdata
);
   vfd_fp_type prog [0:63];
   logic slow = 1'b0;
   logic done = 1'b0;
   int cnt = 0;
   initial
   begin
      pmem_rvalid = 1'b0;
      pmem_rdata = '0;
   end
   always @(posedge clk_sys)
   begin
      pmem_rvalid <= 1'b0;
      // idle bus keeps changing
      pmem_rdata <= ~pmem_rdata;
      if (!resetn || !pmem_req)
      begin
         cnt <= 0;
         done <= 1'b0;
      end
      else if (!done && cnt >= (slow ? int'(pmem_addr[8:5]) + 1 : 0))
      begin
         pmem_rvalid <= 1'b1;
         pmem_rdata <= prog[pmem_addr[10:5]];
         done <= 1'b1;
      end
      else
         cnt <= cnt + 1;
   end
endmodule : vfd_pmem_model
`default_nettype wire

/* File: sim/tb_top.sv */
// tb_top: feeds chained instruction streams and checks every issued packet.
// assumes: design and program memory model share clk_sys.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin err_total++; \
   $display("[FAIL] %0t %s", $time, m); end end
module tb_top;
   import vfd_pkg::*;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic pmem_req;
   logic pmem_rvalid;
   logic [31:0] pmem_addr;
   vfd_fp_type pmem_rdata;
   vfd_bundle_type fu_issue;
   vfd_bundle_type expq [$];
   int nbefore [0:63];
   int err_total = 0;
   int num_checks = 0;
   int issued = 0;
   int fetches = 0;
   logic [31:0] lfsr = 32'hd3f7;
   always #2 clk_sys = ~clk_sys;
   vfd_fetch_dispatch vfd_fetch_dispatch_inst (.clk_sys(clk_sys), .resetn(resetn),
      .pmem_req(pmem_req), .pmem_addr(pmem_addr), .pmem_rvalid(pmem_rvalid),
      .pmem_rdata(pmem_rdata), .fu_issue(fu_issue));
   vfd_pmem_model vfd_pmem_model_inst (.clk_sys(clk_sys), .resetn(resetn),
      .pmem_req(pmem_req), .pmem_addr(pmem_addr), .pmem_rvalid(pmem_rvalid),
      .pmem_rdata(pmem_rdata));
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   // mode 0 no chaining, 1 all chained, 2 random chaining
   task automatic run_test(input int mode, input logic slow);
      vfd_bundle_type cur;
      int n;
      int k;
      logic [31:0] w;
      cur = '0;
      n = 0;
      @(posedge clk_sys);
      resetn <= 1'b0;
      @(posedge clk_sys);
      expq.delete();
      for (k = 0; k < 512; k++)
      begin
         lfsr = lfsr_next(lfsr);
         w = lfsr;
         if (mode < 2)
            w[0] = mode[0];
         vfd_pmem_model_inst.prog[k / 8][k % 8] = w;
         if (k % 8 == 0)
            nbefore[k / 8] = expq.size();
         cur[w[3:1]].valid = 1'b1;
         cur[w[3:1]].insn = w;
         n++;
         if (!w[0] || n == 8)
         begin
            expq.push_back(cur);
            cur = '0;
            n = 0;
         end
      end
      vfd_pmem_model_inst.slow = slow;
      repeat (20) @(posedge clk_sys);
      resetn <= 1'b1;
      for (k = 0; k < 8000 && expq.size() > 0; k++)
         @(posedge clk_sys);
      `CHK(expq.size(), 0, "packets missing")
      $display("test mode %0d slow %0d done", mode, slow);
   endtask : run_test
   always @(posedge clk_sys)
   begin : b_check
      vfd_bundle_type e;
      logic any;
      if (!resetn)
      begin
         issued = 0;
         fetches = 0;
      end
      else
      begin
         if (pmem_req === 1'b1 && pmem_rvalid === 1'b1)
         begin
            `CHK(pmem_addr, RESET_PC + FP_BYTES * fetches, "fetch address")
            if (fetches < 64)
               `CHK(issued, nbefore[fetches], "early fetch")
            fetches++;
         end
         any = 1'b0;
         for (int i = 0; i < 8; i++)
            any = any | fu_issue[i].valid;
         if (any === 1'b1 && expq.size() > 0)
         begin
            e = expq.pop_front();
            issued++;
            for (int i = 0; i < 8; i++)
            begin
               `CHK(fu_issue[i].valid, e[i].valid, "slot valid")
               if (e[i].valid)
               begin
                  `CHK(fu_issue[i].insn, e[i].insn, "slot word")
                  `CHK(fu_issue[i].unit, vfd_unit_type'(i), "slot unit")
                  `CHK(fu_issue[i].src, e[i].insn[9:5], "source reg")
                  `CHK(fu_issue[i].dst, e[i].insn[14:10], "dest reg")
                  `CHK(fu_issue[i].xpath, e[i].insn[4], "cross path")
                  `CHK(fu_issue[i].mem, i == 3 || i == 4, "mem flag")
                  `CHK(fu_issue[i].store, (i == 3 || i == 4) && e[i].insn[21], "store")
                  if (i == 2 || i == 5)
                     `CHK(fu_issue[i].mop, e[i].insn[18:15] <= MOP_MAX ?
                        vfd_mop_type'(e[i].insn[18:15]) : MOP_NONE, "mul op")
                  else if (i == 3 || i == 4)
                     `CHK(fu_issue[i].size, vfd_msize_type'(e[i].insn[23:22]), "size")
                  else
                     `CHK(fu_issue[i].simd, e[i].insn[20:19] == 2'h3 ? SIMD_W32 :
                        vfd_simd_type'(e[i].insn[20:19]), "simd")
               end
            end
         end
      end
   end
   initial
   begin
      #240000;
      err_total++;
      $display("[FAIL] %0t watchdog expired", $time);
      report_and_stop();
   end
   initial
   begin
      for (int m = 0; m < 3; m++)
         for (int s = 0; s < 2; s++)
            run_test(m, s[0]);
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
